// *** verilog/timer_two.sv ***
// timer two: 16-bit capture / auto-reload up-down timer with clock output.
// assumes an axi4-lite master on clk_sys; pins sampled through synchronisers.
// Functional notes
// R1 - capture mode without trigger: free 16-bit count, overflow sets overflow flag
// R2 - capture with trigger: external falling edge copies count into reload bytes
// R3 - qualifying external edge sets external flag; both flags request interrupt
// R4 - reset clears down-count enable, so counting is up by default
// R5 - up-only reload: count to FFFFh, set overflow flag, reload from pair
// R6 - up-only with trigger: reload on overflow or external falling edge, flag set
// R7 - up/down with input high: count up, overflow at FFFFh, reload from pair
// R8 - up/down with input low: down, at reload value set flag, load FFFFh
// R9 - up/down: external flag toggles each over/underflow, never interrupts
// R10 - software clears counter select, sets clock-out enable; run starts clock
// R11 - clock-out rate is oscillator over four times (65536 minus reload)
// R12 - clock-out roll-overs raise no interrupt, as in baud mode
// R13 - baud generation and clock-out share the single reload pair
// R14 - clock-out pin doubles as external count input
// R15 - counter select set: count falling edges of external count input
// R16 - baud source selected: overflow flag is never set
// R17 - baud source selected: capture select ignored, reload on every overflow
// R18 - software clears both flags; hardware clears only the external flag, by its up/down toggle
// R19 - external input synchronised, falling edge found from successive samples
// R20 - clock-out pin toggles each roll-over while enabled and running
`timescale 1ns/1ps
`default_nettype none
module timer_two
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // axi4-lite slave
  input  wire logic [11:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [11:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // pins
  input  wire logic        external_input,
  input  wire logic        clock_out_pin_in,
  output logic             clock_out_pin_out,
  output logic             clock_out_pin_oe,
  output logic             timer_irq,
  output logic             baud_tick
);

  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] timer_two_control_reg;
  logic [7:0] timer_two_mode_reg;
  logic [3:0] tick_div;
  logic       clk_level;

  function automatic logic [7:0] word_index(input logic [11:0] a);
    word_index = a[9:2];
  endfunction : word_index

  function automatic logic known_index(input logic [7:0] i);
    known_index = (i >= timer_two_pkg::IDX_CONTROL) && (i <= timer_two_pkg::IDX_COUNT_HIGH);
  endfunction : known_index

  // ---------------- pin conditioning ----------------
  wire ext_level;
  wire ext_fall;
  wire cnt_level;
  wire cnt_fall;

  edge_sync u_ext_sync
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin     (external_input),
    .level   (ext_level),
    .fall    (ext_fall)
  ); // [R19]

  // pin reads back its own level when driven, so only count when counter mode [R14]
  edge_sync u_cnt_sync
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin     (clock_out_pin_in),
    .level   (cnt_level),
    .fall    (cnt_fall)
  );

  // ---------------- decode of mode bits ----------------
  wire run         = timer_two_control_reg[timer_two_pkg::CTL_RUN];
  wire cnt_sel     = timer_two_control_reg[timer_two_pkg::CTL_CNTSEL];
  wire baud_mode   = timer_two_control_reg[timer_two_pkg::CTL_RXBAUD]
                   | timer_two_control_reg[timer_two_pkg::CTL_TXBAUD];
  wire ext_en      = timer_two_control_reg[timer_two_pkg::CTL_EXTEN];
  wire cap_mode    = timer_two_control_reg[timer_two_pkg::CTL_CAPSEL] & ~baud_mode; // [R17]
  wire down_count_enable        = timer_two_mode_reg[timer_two_pkg::MOD_DOWN_COUNT_ENABLE];
  wire clkout_en   = timer_two_mode_reg[timer_two_pkg::MOD_CLKOE] & ~cnt_sel; // [R10]
  wire updown      = down_count_enable & ~cap_mode & ~baud_mode;
  wire count_down  = updown & ~ext_level; // [R7] [R8]
  // baud and clock-out modes run at oscillator/2 so rate is fosc/(4*(65536-reload)) [R11]
  wire fast_mode   = baud_mode | clkout_en;
  // every second clock; relies on the divider length being even
  wire fast_tick   = tick_div[0]; // [R11]
  wire slow_tick   = tick_div == timer_two_pkg::TICK_LAST;
  wire tick        = cnt_sel ? cnt_fall : (fast_mode ? fast_tick : slow_tick); // [R15]
  wire step        = run & tick;

  wire [15:0] count  = {count_high_byte, count_low_byte};
  wire [15:0] reload = {reload_high_byte, reload_low_byte}; // shared by baud and clock-out [R13]

  wire at_top      = count == timer_two_pkg::COUNT_TOP;
  wire at_bottom   = count == reload;
  wire overflow    = step & ~count_down & at_top; // [R1] [R5] [R7]
  wire underflow   = step & count_down & at_bottom; // [R8]
  wire roll        = overflow | underflow;
  // external trigger is ignored while the timer feeds the serial port
  wire ext_trig    = run & ext_en & ext_fall & ~updown & ~baud_mode;
  wire capture     = ext_trig & cap_mode; // [R2]
  wire ext_reload  = ext_trig & ~cap_mode; // [R6]

  logic [15:0] next_count;
  always_comb
  begin
    next_count = count;
    if (underflow)
      next_count = timer_two_pkg::COUNT_TOP; // [R8]
    else if (overflow && !cap_mode)
      next_count = reload; // [R5] [R7] [R17]
    else if (ext_reload)
      next_count = reload; // [R6]
    else if (step && count_down)
      next_count = 16'(count - 16'h0001);
    else if (step)
      next_count = 16'(count + 16'h0001); // [R1]
  end

  // ---------------- axi4-lite slave ----------------
  logic [11:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;

  // a write waits while an earlier response is still unanswered
  wire        wr_go    = aw_held & w_held & ~s_bvalid;
  wire [7:0]  wr_idx   = word_index(aw_addr);
  wire        wr_ok    = known_index(wr_idx) & (aw_addr[11:10] == 2'b00);
  wire        wr_lane0 = wr_go & wr_ok & w_strb[0];
  wire [7:0]  wr_byte  = w_data[7:0];
  wire [7:0]  rd_idx   = word_index(s_araddr);
  wire        rd_ok    = known_index(rd_idx) & (s_araddr[11:10] == 2'b00);
  wire        rd_go    = s_arvalid & s_arready;

  wire wr_ctl  = wr_lane0 && wr_idx == timer_two_pkg::IDX_CONTROL;
  wire wr_mod  = wr_lane0 && wr_idx == timer_two_pkg::IDX_MODE;
  wire wr_rl   = wr_lane0 && wr_idx == timer_two_pkg::IDX_RELOAD_LOW;
  wire wr_rh   = wr_lane0 && wr_idx == timer_two_pkg::IDX_RELOAD_HIGH;
  wire wr_cl   = wr_lane0 && wr_idx == timer_two_pkg::IDX_COUNT_LOW;
  wire wr_ch   = wr_lane0 && wr_idx == timer_two_pkg::IDX_COUNT_HIGH;

  // read data decodes the address the master holds; no address latch is needed
  logic [7:0] rd_byte;
  always_comb
  begin
    unique case (rd_idx)
      timer_two_pkg::IDX_CONTROL:     rd_byte = timer_two_control_reg;
      timer_two_pkg::IDX_MODE:        rd_byte = timer_two_mode_reg;
      timer_two_pkg::IDX_RELOAD_LOW:  rd_byte = reload_low_byte;
      timer_two_pkg::IDX_RELOAD_HIGH: rd_byte = reload_high_byte;
      timer_two_pkg::IDX_COUNT_LOW:   rd_byte = count_low_byte;
      timer_two_pkg::IDX_COUNT_HIGH:  rd_byte = count_high_byte;
      default:                        rd_byte = timer_two_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_addr   <= '0;
      aw_held   <= 1'b0;
      w_data    <= '0;
      w_strb    <= '0;
      w_held    <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= timer_two_pkg::RESP_OKAY;
    end
    else
    begin
      s_awready <= ~aw_held & ~(s_awvalid & s_awready) & ~s_bvalid;
      s_wready  <= ~w_held & ~(s_wvalid & s_wready) & ~s_bvalid;
      if (s_awvalid && s_awready)
      begin
        aw_addr <= s_awaddr;
        aw_held <= 1'b1;
      end
      if (s_wvalid && s_wready)
      begin
        w_data <= s_wdata;
        w_strb <= s_wstrb;
        w_held <= 1'b1;
      end
      if (wr_go)
      begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? timer_two_pkg::RESP_OKAY : timer_two_pkg::RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= timer_two_pkg::RESP_OKAY;
    end
    else
    begin
      s_arready <= ~s_rvalid & ~rd_go;
      if (rd_go)
      begin
        s_rvalid <= 1'b1;
        s_rdata  <= {24'h000000, rd_byte};
        s_rresp  <= rd_ok ? timer_two_pkg::RESP_OKAY : timer_two_pkg::RESP_SLVERR;
      end
      else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  // ---------------- flags ----------------
  // hardware only ever sets or toggles; a write of zero clears, and a same-cycle event wins
  // roll-overs that feed the serial port or the pin must not reach the flag
  wire quiet    = baud_mode | clkout_en; // [R12]
  wire set_ovf  = roll & ~quiet; // [R16]
  wire set_ext  = capture | ext_reload; // [R3] [R6]
  wire ovf_now  = timer_two_control_reg[timer_two_pkg::CTL_OVF];
  wire ext_now  = timer_two_control_reg[timer_two_pkg::CTL_EXT];
  wire ovf_base = wr_ctl ? wr_byte[timer_two_pkg::CTL_OVF] : ovf_now; // [R18]
  wire ext_base = wr_ctl ? wr_byte[timer_two_pkg::CTL_EXT] : ext_now; // [R18]
  wire next_ovf = ovf_base | set_ovf;
  // toggle acts on the current value so a clearing write cannot mask the extra bit [R9]
  wire next_ext = (updown && roll) ? ~ext_now : (ext_base | set_ext);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_two_control_reg <= timer_two_pkg::RESET_BYTE;
      timer_two_mode_reg    <= timer_two_pkg::RESET_BYTE; // [R4]
    end
    else
    begin
      timer_two_control_reg[timer_two_pkg::CTL_OVF] <= next_ovf;
      timer_two_control_reg[timer_two_pkg::CTL_EXT] <= next_ext;
      if (wr_ctl)
        timer_two_control_reg[5:0] <= wr_byte[5:0];
      if (wr_mod)
        timer_two_mode_reg <= {6'b000000, wr_byte[1:0]};
    end
  end

  // ---------------- counter and reload pair ----------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      count_low_byte   <= timer_two_pkg::RESET_BYTE;
      count_high_byte  <= timer_two_pkg::RESET_BYTE;
      reload_low_byte  <= timer_two_pkg::RESET_BYTE;
      reload_high_byte <= timer_two_pkg::RESET_BYTE;
      tick_div         <= '0;
    end
    else
    begin
      // divider runs free, so the first tick after a start may come early
      tick_div <= (tick_div == timer_two_pkg::TICK_LAST) ? 4'h0 : 4'(tick_div + 4'h1);
      // a software write to a count byte wins over counting in that cycle
      count_low_byte  <= wr_cl ? wr_byte : next_count[7:0];
      count_high_byte <= wr_ch ? wr_byte : next_count[15:8];
      // capture wins over a software write to the reload pair
      if (capture)
      begin
        reload_low_byte  <= count_low_byte; // [R2]
        reload_high_byte <= count_high_byte;
      end
      else
      begin
        if (wr_rl)
          reload_low_byte <= wr_byte;
        if (wr_rh)
          reload_high_byte <= wr_byte;
      end
    end
  end

  // ---------------- outputs ----------------
  // underflows toggle too, so up/down counting still gives a usable clock
  wire clk_toggle = clkout_en & run & roll; // [R20]

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_level         <= 1'b1;
      clock_out_pin_out <= 1'b1;
      clock_out_pin_oe  <= 1'b0;
      timer_irq         <= 1'b0;
      baud_tick         <= 1'b0;
    end
    else
    begin
      if (clk_toggle)
        clk_level <= ~clk_level; // [R20]
      clock_out_pin_out <= clk_level;
      clock_out_pin_oe  <= clkout_en; // [R14]
      // clock-out and baud roll-overs never reach the flag, hence no interrupt [R12]
      timer_irq <= next_ovf | (next_ext & ~updown); // [R3] [R9]
      baud_tick <= overflow & baud_mode; // [R13]
    end
  end

endmodule : timer_two
`default_nettype wire

// *** verilog/timer_two_pkg.sv ***
// timer two package: register offsets, field positions, reset values, timing constants.
// assumes a 32-bit axi4-lite register bus, one aligned word per register.
package timer_two_pkg;

  // printed offsets are sfr addresses, not multiples of four: kept as indices
  localparam logic [7:0]  IDX_COUNT_LOW   = 8'hCC;
  localparam logic [7:0]  IDX_COUNT_HIGH  = 8'hCD;
  localparam logic [7:0]  IDX_RELOAD_LOW  = 8'hCA;
  localparam logic [7:0]  IDX_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0]  IDX_MODE        = 8'hC9;
  localparam logic [7:0]  IDX_CONTROL     = 8'hC8;

  localparam int          ADDR_W          = 12;

  // control register fields
  localparam int          CTL_OVF         = 7;
  localparam int          CTL_EXT         = 6;
  localparam int          CTL_RXBAUD      = 5;
  localparam int          CTL_TXBAUD      = 4;
  localparam int          CTL_EXTEN       = 3;
  localparam int          CTL_RUN         = 2;
  localparam int          CTL_CNTSEL      = 1;
  localparam int          CTL_CAPSEL      = 0;
  // mode register fields
  localparam int          MOD_CLKOE       = 1;
  localparam int          MOD_DOWN_COUNT_ENABLE        = 0;

  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [15:0] COUNT_TOP       = 16'hFFFF;

  // internal tick: one machine cycle of twelve core clocks
  localparam int          TICK_DIV        = 12;
  localparam logic [3:0]  TICK_LAST       = 4'(TICK_DIV - 1);

  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  typedef struct packed {
    logic overflow;
    logic ext_event;
    logic reload;
  } timer_event_s;

endpackage : timer_two_pkg

// *** verilog/edge_sync.sv ***
// two-flop synchroniser with falling-edge detect for one external pin.
// assumes the pin may be asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module edge_sync
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  logic meta;
  logic prev;

  // meta is read by level only
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
      prev  <= 1'b1;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  assign fall = prev & ~level;

endmodule : edge_sync
`default_nettype wire

// *** tb/timer_two_properties.sv ***
// checker for timer_two: bus handshakes and clock-out behaviour at the ports.
// assumes it is bound into every timer_two instance.
`timescale 1ns/1ps
`default_nettype none
module timer_two_properties
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic        external_input,
  input wire logic        clock_out_pin_out,
  input wire logic        clock_out_pin_oe,
  input wire logic        timer_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response missing");
  chk_bresp_holds: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read data missing");
  chk_rdata_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  chk_read_busy: assert property (s_rvalid |-> !s_arready)
    else $error("read accepted while busy");
  chk_rdata_byte: assert property (s_rvalid |-> s_rdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  // shortest legal half period is two clocks, with a reload of all ones
  chk_clkout_half: assert property (
    clock_out_pin_oe && $changed(clock_out_pin_out) |=> $stable(clock_out_pin_out))
    else $error("clock out half period too short");
  chk_clkout_quiet: assert property (
    (clock_out_pin_oe && external_input && !timer_irq) [*4] |=> !timer_irq)
    else $error("clock out raised interrupt");
endmodule : timer_two_properties

bind timer_two timer_two_properties chk (.clk_sys, .resetn, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_rvalid, .s_rready,
  .s_rdata, .external_input, .clock_out_pin_out, .clock_out_pin_oe, .timer_irq);
`default_nettype wire

// *** tb/pin_model.sv ***
// pin model: trigger input and the shared count-in / clock-out pin.
// assumes the bench steers trig_level and count_en after clock edges.
`timescale 1ns/1ps
`default_nettype none
module pin_model
(
  input  wire logic clk_sys,
  input  wire logic trig_level,
  input  wire logic count_en,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      external_input,
  output logic      clock_out_pin_in
);
  logic [2:0] div;
  logic       src;
  initial div = 3'h0;
  initial src = 1'b1;
  always @(posedge clk_sys)
  begin
    div <= count_en ? div + 3'h1 : 3'h0;
    if (count_en && div == 3'h7)
      src <= ~src;
    else if (!count_en)
      src <= 1'b1;
  end
  assign external_input = trig_level;
  // pull-up keeps the shared pin high while nobody drives it
  assign clock_out_pin_in = pin_oe ? pin_out : (count_en ? src : 1'b1);
endmodule : pin_model
`default_nettype wire

// *** tb/test_timer_two.sv ***
// bench for timer_two: register table, capture, reload, up/down, clock-out, counter, baud.
// assumes pin_model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_timer_two;
  localparam logic [7:0] CTL = timer_two_pkg::IDX_CONTROL;
  localparam logic [7:0] MD  = timer_two_pkg::IDX_MODE;
  localparam logic [7:0] RL  = timer_two_pkg::IDX_RELOAD_LOW;
  localparam logic [7:0] RH  = timer_two_pkg::IDX_RELOAD_HIGH;
  localparam logic [7:0] CL  = timer_two_pkg::IDX_COUNT_LOW;
  localparam logic [7:0] CH  = timer_two_pkg::IDX_COUNT_HIGH;
  typedef struct packed { logic [7:0] idx; logic [7:0] val; logic [1:0] resp; } row_s;
  logic        clk_sys, resetn, trig, cnt_en;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic        ext_in, pin_in, pin_out, pin_oe, timer_irq, baud_tick;
  int          bad_count, num_checks, k;
  logic [7:0]  d;
  logic [1:0]  r;
  row_s        rows [7];

  timer_two dut (.clk_sys, .resetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .external_input(ext_in),
    .clock_out_pin_in(pin_in), .clock_out_pin_out(pin_out), .clock_out_pin_oe(pin_oe),
    .timer_irq, .baud_tick);
  pin_model partner (.clk_sys, .trig_level(trig), .count_en(cnt_en), .pin_out, .pin_oe,
    .external_input(ext_in), .clock_out_pin_in(pin_in));

  always #2.5 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic lost(input int n);
    if (n >= 64)
    begin
      bad_count++;
      give_verdict();
    end
  endtask : lost

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    int n;
    n = 0;
    s_awaddr <= {2'b00, idx, 2'b00};
    s_wdata <= {24'h000000, v};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      // answer taken one cycle late so the held response is exercised
      if (s_bvalid && !s_bready) s_bready <= 1'b1;
    end
    while (!(s_bvalid && s_bready) && n < 64);
    s_bready <= 1'b0;
    chk("write response", 8'h00, {6'h00, s_bresp});
    lost(n);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    s_araddr <= {2'b00, idx, 2'b00};
    s_arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && !s_rready) s_rready <= 1'b1;
    end
    while (!(s_rvalid && s_rready) && n < 64);
    v = s_rdata[7:0];
    rs = s_rresp;
    s_rready <= 1'b0;
    lost(n);
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    logic [1:0] rs;
    rd(idx, v, rs);
    chk(nm, e, v);
  endtask : rc

  task automatic half_period(output int n);
    logic v;
    n = 0;
    v = pin_out;
    while (pin_out === v && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    v = pin_out;
    n = 0;
    while (pin_out === v && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : half_period

  task automatic pair(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] h, l);
    wr(hi, h);
    wr(lo, l);
  endtask : pair

  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    {trig, cnt_en} = 2'b10;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {s_awaddr, s_araddr, s_wdata} = '0;
    bad_count = 0;
    num_checks = 0;
    rows = '{'{CTL, 8'h00, 2'b00}, '{MD, 8'h00, 2'b00}, '{RL, 8'h00, 2'b00},
      '{RH, 8'h00, 2'b00}, '{CL, 8'h00, 2'b00}, '{CH, 8'h00, 2'b00}, '{8'h40, 8'h00, 2'b10}};
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i])
    begin
      rd(rows[i].idx, d, r);
      chk("reset value", rows[i].val, d);
      chk("response", {6'h00, rows[i].resp}, {6'h00, r});
    end
    $display("test reset table done");
    pair(CH, CL, 8'h12, 8'h34);
    wr(CTL, 8'h0D);
    repeat (24) @(posedge clk_sys);
    trig <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc("captured high", RH, 8'h12);
    rc("capture flags", CTL, 8'h4D);
    chk("irq", 8'h01, {7'h00, timer_irq});
    trig <= 1'b1;
    wr(CTL, 8'h0D);
    repeat (3) @(posedge clk_sys);
    chk("irq cleared", 8'h00, {7'h00, timer_irq});
    $display("test capture done");
    wr(CTL, 8'h00);
    pair(CH, CL, 8'hFF, 8'hFE);
    pair(RH, RL, 8'h56, 8'h00);
    wr(CTL, 8'h04);
    repeat (40) @(posedge clk_sys);
    rc("reloaded high", CH, 8'h56);
    rc("overflow flag", CTL, 8'h84);
    wr(CTL, 8'h0C);
    wr(CH, 8'h77);
    trig <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc("edge reload", CH, 8'h56);
    rc("edge flag", CTL, 8'h4C);
    $display("test reload done");
    wr(CTL, 8'h00);
    wr(MD, 8'h01);
    pair(RH, RL, 8'h10, 8'h00);
    pair(CH, CL, 8'h10, 8'h02);
    wr(CTL, 8'h04);
    repeat (60) @(posedge clk_sys);
    rc("underflow load", CH, 8'hFF);
    rc("down flags", CTL, 8'hC4);
    wr(CTL, 8'h44);
    repeat (3) @(posedge clk_sys);
    chk("no ext irq", 8'h00, {7'h00, timer_irq});
    trig <= 1'b1;
    pair(CH, CL, 8'hFF, 8'hFE);
    repeat (40) @(posedge clk_sys);
    rc("up reload", CH, 8'h10);
    rc("up flags", CTL, 8'h84);
    $display("test up down done");
    wr(CTL, 8'h00);
    wr(MD, 8'h02);
    pair(RH, RL, 8'hFF, 8'hF0);
    // preset the count so the first roll-over comes soon
    pair(CH, CL, 8'hFF, 8'hF0);
    wr(CTL, 8'h04);
    repeat (4) @(posedge clk_sys);
    chk("pin drive", 8'h01, {7'h00, pin_oe});
    half_period(k);
    chk("half period", 8'h20, k[7:0]);
    chk("no irq", 8'h00, {7'h00, timer_irq});
    wr(CTL, 8'h00);
    d = {7'h00, pin_out};
    repeat (100) @(posedge clk_sys);
    chk("held level", d, {7'h00, pin_out});
    $display("test clock out done");
    wr(MD, 8'h00);
    pair(CH, CL, 8'h00, 8'h00);
    wr(CTL, 8'h06);
    repeat (4) @(posedge clk_sys);
    chk("pin released", 8'h00, {7'h00, pin_oe});
    cnt_en <= 1'b1;
    repeat (80) @(posedge clk_sys);
    cnt_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc("event count", CL, 8'h05);
    $display("test counter done");
    wr(CTL, 8'h00);
    pair(RH, RL, 8'hFF, 8'hFE);
    pair(CH, CL, 8'hFF, 8'hFE);
    wr(CTL, 8'h25);
    k = 0;
    repeat (40)
    begin
      @(posedge clk_sys);
      k += int'(baud_tick === 1'b1);
    end
    chk("baud ticks", 8'h01, {7'h00, k >= 9 && k <= 11});
    rc("no baud flag", CTL, 8'h25);
    wr(MD, 8'h02);
    repeat (4) @(posedge clk_sys);
    half_period(k);
    chk("shared half", 8'h04, k[7:0]);
    $display("test baud done");
    give_verdict();
  end
endmodule : test_timer_two
`default_nettype wire
